// ---- sim/frame_sync_alignment_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module frame_sync_alignment_tb;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       ref_19 = 1'b0;
   logic       frame_tick = 1'b0;
   logic       go = 1'b0;
   logic [3:0] dly = 4'h0;
   logic [1:0] tick_cnt = 2'h0;
   logic [7:0] rdata;
   logic       ext_sync, fs8k, ms2k, realign;
   int         error_cnt = 0;
   int         n_compared = 0;

   always #25 clk = ~clk;
   // coarse tick every 4th cycle, stands in for the 6.48 MHz reference
   always @(posedge clk) tick_cnt <= tick_cnt + 2'h1;

   fsa_top dut (
      .clk                       (clk),
      .arst_n                    (arst_n),
      .addr                      (addr),
      .wdata                     (wdata),
      .wr                        (wr),
      .rd                        (rd),
      .rdata                     (rdata),
      .ref_is_19m44              (ref_19),
      .sample_tick_6m48          (tick_cnt == 2'h0),
      .sample_tick_19m44         (tick_cnt[0]),
      .sample_tick_38m88         (1'b1),
      .clk_frame_tick            (frame_tick),
      .ext_2k_sync_input         (ext_sync),
      .frame_sync_8k_output      (fs8k),
      .multiframe_sync_2k_output (ms2k),
      .oc_realign                (realign)
   );

   fsa_sync_src_model src (
      .clk     (clk),
      .trigger (go),
      .delay   (dly),
      .sync    (ext_sync)
   );

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask

   // one ext edge, optional internal frame ticks, then count output pulses
   task automatic run_case(input logic [7:0] cfg, input logic [3:0] d, input int ticks,
                           input int ef, input int em, input int er);
      int nf, nm, nr;
      nf = 0;
      nm = 0;
      nr = 0;
      wr_reg(fsa_pkg::SYNC_PHASE_CONFIG_ADDR, cfg);
      dly <= d;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         frame_tick <= (i % 10 == 5) && (i / 10 < ticks);
         #1;
         if (fs8k === 1'b1) nf++;
         if (ms2k === 1'b1) nm++;
         if (realign === 1'b1) nr++;
      end
      chk("frame pulses", 8'(ef), 8'(nf));
      chk("multiframe pulses", 8'(em), 8'(nm));
      chk("realign pulses", 8'(er), 8'(nr));
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard
   initial begin
      #2_000_000;
      error_cnt++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(fsa_pkg::SYNC_PHASE_CONFIG_ADDR, 8'h00, "config reset");
      rd_chk(fsa_pkg::SYNC_STATUS_ADDR, 8'h00, "coarse precision");
      wr_reg(fsa_pkg::SYNC_PHASE_CONFIG_ADDR, 8'hFF);
      rd_chk(fsa_pkg::SYNC_PHASE_CONFIG_ADDR, 8'hC3, "unused bits");
      rd_chk(fsa_pkg::SYNC_STATUS_ADDR, 8'h02, "fine 38.88");
      ref_19 <= 1'b1;
      rd_chk(fsa_pkg::SYNC_STATUS_ADDR, 8'h01, "fine 19.44");
      ref_19 <= 1'b0;
      rd_chk(8'h5A, 8'h00, "unmapped read");
      run_case(8'h00, 4'h0, 0, 0, 0, 0);
      run_case(8'h80, 4'h0, 0, 1, 1, 0);
      run_case(8'h81, 4'h9, 0, 1, 1, 0);
      run_case(8'h82, 4'h0, 0, 1, 1, 0);
      run_case(8'h83, 4'h3, 0, 1, 1, 0);
      run_case(8'hC0, 4'h9, 0, 1, 1, 1);
      run_case(8'h00, 4'h0, 4, 4, 1, 0);
      end_sim();
   end
endmodule

`default_nettype wire

// ---- sim/fsa_sync_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// far-side 2 kHz sync source: one rising edge per trigger
module fsa_sync_src_model #(
   parameter int HOLD = 20
) (
   input  wire logic       clk,
   input  wire logic       trigger,
   input  wire logic [3:0] delay,
   output logic            sync
);
   int cnt = 0;
   initial sync = 1'b0;
   // edge after a chosen delay, held for five coarse ticks so late taps see it
   always @(posedge clk) begin
      if (trigger)
         cnt <= int'(delay) + HOLD;
      else if (cnt > 0)
         cnt <= cnt - 1;
      sync <= (cnt > 0) && (cnt <= HOLD);
   end
endmodule

`default_nettype wire

// ---- src/fsa_edge_sampler.sv ----
`timescale 1ns/10ps
`default_nettype none

// samples sync input with phase offset, reports rising edge
module fsa_edge_sampler (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // control
   input  wire fsa_pkg::fsa_phase_e phase,
   // sync input and tick
   input  wire logic              sync_in,
   input  wire logic              sample_tick,
   output logic                   edge_seen
);

   logic [4:0] hist_reg;
   logic [4:0] hist_next;
   logic       sel;

   // shift history on each sample tick
   always_comb begin
      hist_next = hist_reg;
      if (sample_tick) begin
         hist_next = {hist_reg[3:0], sync_in};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hist_reg <= 5'h00;
      end else begin
         hist_reg <= hist_next;
      end
   end

   // pick sampling instant; early uses newest, late uses older taps
   // half-unit steps are rounded to whole ticks, the tick grid is the limit
   always_comb begin
      case (phase)
         fsa_pkg::FSA_PH_TARGET:     sel = hist_reg[1] & ~hist_reg[2];
         fsa_pkg::FSA_PH_EARLY_HALF: sel = hist_reg[0] & ~hist_reg[1];
         fsa_pkg::FSA_PH_LATE_ONE:   sel = hist_reg[3] & ~hist_reg[4];
         fsa_pkg::FSA_PH_LATE_HALF:  sel = hist_reg[2] & ~hist_reg[3];
         default:                    sel = 1'b0;
      endcase
   end

   assign edge_seen = sel & sample_tick;

endmodule

`default_nettype wire

// ---- src/fsa_pkg.sv ----
package fsa_pkg;

   // register map
   localparam logic [7:0] SYNC_PHASE_CONFIG_ADDR  = 8'h00;
   localparam logic [7:0] SYNC_STATUS_ADDR        = 8'h01;
   localparam logic [7:0] SYNC_PHASE_CONFIG_RESET = 8'h00;
   localparam logic [7:0] SYNC_PHASE_CONFIG_MASK  = 8'hC3;

   // field positions
   localparam int INDEP_BIT = 7;
   localparam int FINE_BIT  = 6;

   // last frame count of a multiframe: four 8 kHz frames per 2 kHz multiframe
   localparam logic [1:0] FRAMES_PER_MULTI = 2'h3;

   // sampling precision modes
   typedef enum logic [1:0] {
      FSA_PREC_6M48,
      FSA_PREC_19M44,
      FSA_PREC_38M88
   } fsa_prec_e;

   // phase offsets
   typedef enum logic [1:0] {
      FSA_PH_TARGET,
      FSA_PH_EARLY_HALF,
      FSA_PH_LATE_ONE,
      FSA_PH_LATE_HALF
   } fsa_phase_e;

   typedef struct packed {
      logic       sync_independence_select;
      logic       sync_fine_sampling_select;
      fsa_phase_e sync_phase;
   } fsa_cfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fsa_bus_s;

endpackage

// ---- src/fsa_sync_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

// 8 kHz / 2 kHz pulse generator, realigned by a request
module fsa_sync_gen (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // timing
   input  wire logic frame_tick,
   input  wire logic realign,
   // outputs
   output logic      frame_sync_8k_output,
   output logic      multiframe_sync_2k_output
);

   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic       fr_reg;
   logic       fr_next;
   logic       mf_reg;
   logic       mf_next;

   // realign restarts the multiframe at frame zero
   always_comb begin
      cnt_next = cnt_reg;
      fr_next  = 1'b0;
      mf_next  = 1'b0;
      if (realign) begin
         cnt_next = 2'h0;
         fr_next  = 1'b1;
         mf_next  = 1'b1;
      end else if (frame_tick) begin
         cnt_next = (cnt_reg == fsa_pkg::FRAMES_PER_MULTI) ? 2'h0 : 2'(cnt_reg + 2'h1);
         fr_next  = 1'b1;
         mf_next  = (cnt_next == 2'h0);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 2'h0;
         fr_reg  <= 1'b0;
         mf_reg  <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         fr_reg  <= fr_next;
         mf_reg  <= mf_next;
      end
   end

   assign frame_sync_8k_output      = fr_reg;
   assign multiframe_sync_2k_output = mf_reg;

endmodule

`default_nettype wire

// ---- src/fsa_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module fsa_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   // clocking context
   input  wire logic        ref_is_19m44,
   input  wire logic        sample_tick_6m48,
   input  wire logic        sample_tick_19m44,
   input  wire logic        sample_tick_38m88,
   input  wire logic        clk_frame_tick,
   // external sync and outputs
   input  wire logic        ext_2k_sync_input,
   output logic             frame_sync_8k_output,
   output logic             multiframe_sync_2k_output,
   output logic             oc_realign
);

   logic             rst_s1_reg;
   logic             rst_n_reg;
   fsa_pkg::fsa_cfg_s cfg_reg;
   fsa_pkg::fsa_cfg_s cfg_next;
   logic [7:0]       rdata_reg;
   logic [7:0]       rdata_next;
   fsa_pkg::fsa_prec_e prec;
   logic             tick;
   logic             edge_seen;
   logic             realign;

   function automatic logic [7:0] cfg_word(input fsa_pkg::fsa_cfg_s c);
      cfg_word = {c.sync_independence_select, c.sync_fine_sampling_select, 4'h0, c.sync_phase};
   endfunction

   // reset release through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg  <= rst_s1_reg;
      end
   end

   // register write and read; unused bits dropped
   always_comb begin
      cfg_next   = cfg_reg;
      rdata_next = 8'h00;
      if (wr && addr == fsa_pkg::SYNC_PHASE_CONFIG_ADDR) begin
         cfg_next = fsa_pkg::fsa_cfg_s'({wdata[7:6], wdata[1:0]});
      end
      if (rd) begin
         case (addr)
            fsa_pkg::SYNC_PHASE_CONFIG_ADDR: rdata_next = cfg_word(cfg_reg) & fsa_pkg::SYNC_PHASE_CONFIG_MASK;
            fsa_pkg::SYNC_STATUS_ADDR:       rdata_next = {6'h00, 2'(prec)};
            default:                         rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cfg_reg   <= fsa_pkg::fsa_cfg_s'({fsa_pkg::SYNC_PHASE_CONFIG_RESET[7:6],
                                           fsa_pkg::SYNC_PHASE_CONFIG_RESET[1:0]});
         rdata_reg <= 8'h00;
      end else begin
         cfg_reg   <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end
   assign rdata = rdata_reg;

   // sampling precision selection
   always_comb begin
      if (!cfg_reg.sync_fine_sampling_select) begin
         prec = fsa_pkg::FSA_PREC_6M48;
         tick = sample_tick_6m48;
      end else if (ref_is_19m44) begin
         prec = fsa_pkg::FSA_PREC_19M44;
         tick = sample_tick_19m44;
      end else begin
         prec = fsa_pkg::FSA_PREC_38M88;
         tick = sample_tick_38m88;
      end
   end

   fsa_edge_sampler u_samp (
      .clk         (clk),
      .rst_n       (rst_n_reg),
      .phase       (cfg_reg.sync_phase),
      .sync_in     (ext_2k_sync_input),
      .sample_tick (tick),
      .edge_seen   (edge_seen)
   );

   // independent mode follows external edge; aligned mode ignores it
   assign realign = cfg_reg.sync_independence_select & edge_seen;

   // oc clocks realign only in fine mode
   assign oc_realign = cfg_reg.sync_fine_sampling_select & edge_seen;

   fsa_sync_gen u_gen (
      .clk                       (clk),
      .rst_n                     (rst_n_reg),
      .frame_tick                (clk_frame_tick),
      .realign                   (realign),
      .frame_sync_8k_output      (frame_sync_8k_output),
      .multiframe_sync_2k_output (multiframe_sync_2k_output)
   );

   sequence realign_s;
      realign;
   endsequence

   sequence both_high_s;
      frame_sync_8k_output && multiframe_sync_2k_output;
   endsequence

   aligned_no_follow_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      (!cfg_reg.sync_independence_select && edge_seen && !clk_frame_tick) |=> !frame_sync_8k_output)
      else $error("aligned mode followed external sync");

   indep_follow_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      (cfg_reg.sync_independence_select && edge_seen) |-> realign)
      else $error("independent mode missed sync");

   indep_realign_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      realign_s |=> both_high_s)
      else $error("sync outputs not realigned");

   coarse_oc_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      !cfg_reg.sync_fine_sampling_select |-> !oc_realign)
      else $error("oc clocks moved in coarse mode");

   coarse_prec_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      !cfg_reg.sync_fine_sampling_select |-> prec == fsa_pkg::FSA_PREC_6M48)
      else $error("coarse precision wrong");

   fine_prec_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      cfg_reg.sync_fine_sampling_select |-> prec == (ref_is_19m44 ? fsa_pkg::FSA_PREC_19M44 : fsa_pkg::FSA_PREC_38M88))
      else $error("fine precision wrong");

   unused_bits_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      (rd && addr == fsa_pkg::SYNC_PHASE_CONFIG_ADDR) |=> rdata[5:2] == 4'h0)
      else $error("unused bits read nonzero");

   write_back_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
      (wr && addr == fsa_pkg::SYNC_PHASE_CONFIG_ADDR) ##1 (rd && addr == fsa_pkg::SYNC_PHASE_CONFIG_ADDR && !wr)
      |=> rdata == ($past(wdata, 2) & fsa_pkg::SYNC_PHASE_CONFIG_MASK))
      else $error("config readback mismatch");

endmodule

`default_nettype wire
